// ---- sim/imdf_core_model.sv ----
// processor-core model: presents operands, collects the result
`include "imdf_map.vh"
module imdf_core_model
(
  input  wire logic        clock,
  input  wire logic        rst,
  output var  logic        operand_latch_strobe,
  output var  logic        float_multiply_op,
  output var  logic        float_divide_op,
  output var  logic        double_precision,
  output var  logic [63:0] first_operand_bus,
  output var  logic [63:0] second_operand_bus,
  input  wire logic [63:0] result_q,
  input  wire logic [31:0] remainder_q,
  input  wire logic        result_valid_q,
  input  wire logic        overflow_flag_q,
  input  wire logic        underflow_flag_q,
  input  wire logic [2:0]  output_select_code_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] res;
  logic [31:0] rem;
  logic [2:0]  sel;
  logic        overflow_flag;
  logic        underflow_flag;
  int          lat;

  initial
  begin
    operand_latch_strobe = 1'b0;
    {float_multiply_op, float_divide_op, double_precision} = 3'h0;
    {first_operand_bus, second_operand_bus} = 128'h0;
  end

  // entered one small delay after an edge, and returns the same way
  task automatic run(input logic [1:0] op, input logic dp,
                     input logic [63:0] x, input logic [63:0] y,
                     input bit poke);
    begin
      operand_latch_strobe = 1'b1;
      float_multiply_op = (op == `IMDF_OP_FMUL);
      float_divide_op = (op == `IMDF_OP_FDIV);
      double_precision = dp;
      first_operand_bus = x;
      second_operand_bus = y;
      @(posedge clock);
      #1;
      operand_latch_strobe = 1'b0;
      // buses no longer held: show the inverse so stale data is caught
      first_operand_bus = ~x;
      second_operand_bus = ~y;
      lat = 0;
      while (result_valid_q !== 1'b1 && lat < 200)
      begin
        @(posedge clock);
        #1;
        lat++;
        // a start while busy must leave the running operation alone
        if (poke && lat <= 3)
          operand_latch_strobe = (lat == 2);
      end
      {res, rem, sel} = {result_q, remainder_q, output_select_code_q};
      {overflow_flag, underflow_flag} = {overflow_flag_q, underflow_flag_q};
    end
  endtask
endmodule

// ---- sim/imdf_muldiv_sva.sv ----
// assertions on the multiply/divide unit's ports
`include "imdf_map.vh"
module imdf_muldiv_chk
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        operand_latch_strobe,
  input wire logic        float_multiply_op,
  input wire logic        float_divide_op,
  input wire logic        double_precision,
  input wire logic [63:0] first_operand_bus,
  input wire logic [63:0] second_operand_bus,
  input wire logic [63:0] result_q,
  input wire logic        result_valid_q,
  input wire logic        busy_q,
  input wire logic        overflow_flag_q,
  input wire logic        underflow_flag_q,
  input wire logic [2:0]  output_select_code_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // timing is held to operands with nonzero exponent fields in bits 62:54
  wire logic go = operand_latch_strobe && !busy_q;
  wire logic nz = |first_operand_bus[62:54] && |second_operand_bus[62:54];
  wire logic fl = float_multiply_op || float_divide_op;
  sequence s_fstart(dp);
    go && fl && nz && double_precision == dp;
  endsequence
  sequence s_done;
    result_valid_q && !busy_q;
  endsequence

  AST_BUSY_RISE: assert property (go |=> busy_q)
    else $error("busy did not rise after a start");
  AST_DBL_TIME: assert property (s_fstart(1'b1) |-> ##32 s_done)
    else $error("double float result late or early");
  AST_SGL_TIME: assert property (s_fstart(1'b0) |-> ##16 s_done)
    else $error("single float result late or early");
  AST_PULSE: assert property (result_valid_q |=> !result_valid_q)
    else $error("result valid longer than one cycle");
  AST_LAST: assert property (result_valid_q |-> $past(busy_q) && !busy_q)
    else $error("result valid outside the last cycle");
  AST_OVF: assert property (
    result_valid_q && overflow_flag_q |->
    output_select_code_q == `IMDF_SEL_ONES)
    else $error("overflow without all-ones select");
  AST_UFL: assert property (
    result_valid_q && underflow_flag_q |->
    output_select_code_q == `IMDF_SEL_ZERO && result_q[62:0] == 63'h0)
    else $error("underflow without zero result");
  AST_EXCL: assert property (!(overflow_flag_q && underflow_flag_q))
    else $error("overflow and underflow together");
  AST_HOLD: assert property (
    !result_valid_q && !$past(rst) |->
    $stable({overflow_flag_q, underflow_flag_q, result_q}))
    else $error("result or flags changed between results");
endmodule

bind imdf_muldiv imdf_muldiv_chk chk_u (.*);

// ---- sim/tb_imdf_muldiv.sv ----
// self-checking bench for the multiply/divide unit
`include "imdf_map.vh"
module tb_imdf_muldiv;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] SGL = 64'h4100_0000_4100_0000;
  logic        clock;
  logic        rst;
  logic        operand_latch_strobe;
  logic        float_multiply_op;
  logic        float_divide_op;
  logic        double_precision;
  logic [63:0] first_operand_bus;
  logic [63:0] second_operand_bus;
  logic [63:0] result_q;
  logic [31:0] remainder_q;
  logic        result_valid_q;
  logic        busy_q;
  logic        overflow_flag_q;
  logic        underflow_flag_q;
  logic [2:0]  output_select_code_q;
  int          errors;
  int          num_checks;
  int          xs[7] = '{-100, 100, -100, 55, 7, 'h7FFFFFFF, -9};
  int          ys[7] = '{7, -7, -7, 5, 'h40000000, 3, 2};

  imdf_muldiv dut_u (.*);
  imdf_core_model core_u (.*);

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    begin
      num_checks++;
      if (got !== exp)
      begin
        errors++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic cmp_st(input logic [4:0] got, input logic [4:0] exp);
    begin
      num_checks++;
      if (got !== exp)
      begin
        errors++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // half times two to the e, zero fraction
  function automatic logic [63:0] fv(input bit s, input int e);
    return {s, 9'(e + 256), 54'h0};
  endfunction

  task automatic idiv(input int x, input int y, input bit p);
    begin
      core_u.run(`IMDF_OP_IDIV, 1'b0, {32'h0, x}, {32'h0, y}, p);
      cmp({32'h0, core_u.res[31:0]}, {32'h0, x / y});
      cmp({32'h0, core_u.rem}, {32'h0, x % y});
    end
  endtask

  // top is sign and biased exponent; st is overflow, underflow, select
  task automatic flt(input logic [1:0] op, input logic dp,
                     input logic [63:0] x, input logic [63:0] y,
                     input logic [9:0] top, input logic [4:0] st);
    begin
      core_u.run(op, dp, x, y, 1'b0);
      if (dp)
        cmp({54'h0, core_u.res[63:54]}, {54'h0, top});
      cmp_st({core_u.overflow_flag, core_u.underflow_flag, core_u.sel}, st);
    end
  endtask

  task automatic conclude();
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial
  begin
    #100us;
    errors++;
    conclude();
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    rst = 1'b0;
    cmp_st({overflow_flag_q, underflow_flag_q, output_select_code_q}, 5'h0);
    idiv(100, 7, 1'b1);
    for (int i = 0; i < 7; i++)
      idiv(xs[i], ys[i], 1'b0);
    flt(`IMDF_OP_FMUL, 1, fv(1, 3), fv(0, 5), 10'h307, 5'h01);
    flt(`IMDF_OP_FDIV, 1, fv(1, 3), fv(1, 5), 10'h0FF, 5'h02);
    flt(`IMDF_OP_FMUL, 1, 64'h0, fv(0, 5), 10'h000, 5'h06);
    flt(`IMDF_OP_FDIV, 1, fv(0, 3), 64'h0, 10'h1FF, 5'h17);
    flt(`IMDF_OP_FMUL, 1, fv(0, 200), fv(1, 100), 10'h3FF, 5'h17);
    flt(`IMDF_OP_FMUL, 1, fv(0, -200), fv(0, -100), 10'h0, 5'h0E);
    flt(`IMDF_OP_FMUL, 1, fv(0, 200), fv(0, 55), 10'h1FE, 5'h01);
    flt(`IMDF_OP_FMUL, 0, SGL, SGL, 10'h0, 5'h01);
    flt(`IMDF_OP_FDIV, 0, SGL, SGL, 10'h0, 5'h02);
    conclude();
  end
endmodule

// ---- verilog/imdf_exp_unit.v ----
// exponent arithmetic: unbias, sign-extend, add or subtract, zero detect
`include "imdf_map.vh"
module imdf_exp_unit
(
  input  wire       clock,
  input  wire       rst,
  input  wire       load,
  input  wire       divide,
  input  wire [9:0] exp_a,
  input  wire [9:0] exp_b,
  output reg  [9:0] exp_sum_q,
  output reg        sign_q,
  output reg        a_zero_q,
  output reg        b_zero_q
);
  wire [9:0] ea;
  wire [9:0] eb;
  // top exponent bit inverted removes the bias, then sign-extended to 10 bits
  assign ea = {~exp_a[8], ~exp_a[8], exp_a[7:0]};
  assign eb = {~exp_b[8], ~exp_b[8], exp_b[7:0]};

  always @(posedge clock)
  begin
    if (rst)
    begin
      exp_sum_q <= 10'h000;
      sign_q    <= 1'b0;
      a_zero_q  <= 1'b0;
      b_zero_q  <= 1'b0;
    end
    else if (load)
    begin
      exp_sum_q <= divide ? ea - eb : ea + eb;
      sign_q    <= exp_a[9] ^ exp_b[9];
      a_zero_q  <= (exp_a[8:0] == 9'h000);
      b_zero_q  <= (exp_b[8:0] == 9'h000);
    end
  end
endmodule

// ---- verilog/imdf_map.vh ----
// offsets, field positions, codes and counts for the multiply/divide unit
`ifndef IMDF_MAP_VH
`define IMDF_MAP_VH
`define IMDF_OP_IDIV      2'h0
`define IMDF_OP_FMUL      2'h1
`define IMDF_OP_FDIV      2'h2
`define IMDF_SEL_MANT     3'h0
`define IMDF_SEL_SHL      3'h1
`define IMDF_SEL_SHR      3'h2
`define IMDF_SEL_ZERO     3'h6
`define IMDF_SEL_ONES     3'h7
`define IMDF_ZERO_CODE    3'h6
`define IMDF_EXP_TOP      62
`define IMDF_SIGN_BIT     63
`define IMDF_EXP_LO       54
`define IMDF_DIV_TOP      54
`define IMDF_MANT_TOP     53
`define IMDF_IDIV_BASE    5'h10
`define IMDF_DBL_ITER     6'h1C
`define IMDF_SGL_ITER     6'h0C
`define IMDF_DBL_KEEP     54
`define IMDF_SGL_KEEP     22
`define IMDF_CYC_LOAD     2'h0
`define IMDF_CYC_ITER     2'h1
`define IMDF_CYC_NORMALIZE_CORRECTION     2'h2
`define IMDF_CYC_PRES     2'h3
`endif

// ---- verilog/imdf_muldiv.v ----
// integer divide and floating multiply/divide datapath, four-state sequence: load, iterate, normalize, present
`include "imdf_map.vh"
module imdf_muldiv
(
  input  wire        clock,
  input  wire        rst,
  input  wire        operand_latch_strobe,
  input  wire        float_multiply_op,
  input  wire        float_divide_op,
  input  wire        double_precision,
  input  wire [63:0] first_operand_bus,
  input  wire [63:0] second_operand_bus,
  output reg  [63:0] result_q,
  output reg  [31:0] remainder_q,
  output reg         result_valid_q,
  output reg         busy_q,
  output reg         overflow_flag_q,
  output reg         underflow_flag_q,
  output reg  [2:0]  output_select_code_q
);
  reg  [1:0]  cyc_q;
  reg  [1:0]  op_q;
  reg  [5:0]  iter_q;
  reg  [56:0] acc_q;
  reg  [54:0] divisor_register_q;
  reg  [55:0] quotient_shift_register_q;
  reg  [4:0]  divisor_shift_length_q;
  reg         a_neg_q;
  reg         b_neg_q;
  reg         dbl_q;
  reg         rem_zero_q;
  reg  [55:0] mcand_q;
  reg  [31:0] a_mag;
  reg  [31:0] b_mag;
  reg  [4:0]  lead;
  reg  [56:0] m1;
  reg  [56:0] m2;
  reg  [56:0] m3;
  reg  [56:0] y_sub;
  reg  [56:0] x_sub;
  reg  [57:0] y_diff;
  reg  [57:0] x_diff;
  reg         y_adder_carry;
  reg         estimate_bit_low;
  reg         estimate_bit_high;
  reg  [1:0]  est;
  reg  [1:0]  qbits;
  reg  [31:0] rem_rev;
  reg  [31:0] rem_sh;
  reg  [31:0] rem_out;
  reg  [9:0]  exp_fix;
  reg         exponent_sum_top;
  reg         exponent_sum_extension;
  reg         normalize_correction;
  reg  [2:0]  sel;
  reg  [52:0] mant;
  reg  [57:0] prod;
  reg  [55:0] qal;
  wire [9:0]  exp_sum;
  wire        res_sign;
  wire        a_zero;
  wire        b_zero;
  wire        start;
  integer     i;

  assign start = operand_latch_strobe & ~busy_q;

  imdf_exp_unit u_exp
  (
    .clock     (clock),
    .rst       (rst),
    .load      (start),
    .divide    (float_divide_op),
    .exp_a     (double_precision ? first_operand_bus[63:54]
                                 : first_operand_bus[31:22]),
    .exp_b     (double_precision ? second_operand_bus[63:54]
                                 : second_operand_bus[31:22]),
    .exp_sum_q (exp_sum),
    .sign_q    (res_sign),
    .a_zero_q  (a_zero),
    .b_zero_q  (b_zero)
  );

  // operand magnitudes and priority encoder for the divisor
  always @*
  begin
    a_mag = first_operand_bus[31] ? ~first_operand_bus[31:0] + 32'h1
                                  : first_operand_bus[31:0];
    b_mag = second_operand_bus[31] ? ~second_operand_bus[31:0] + 32'h1
                                   : second_operand_bus[31:0];
    lead = 5'h00;
    for (i = 0; i < 32; i = i + 1)
      if (b_mag[i])
        lead = i[4:0];
  end

  // estimate from top divisor and remainder bits, paired trial subtraction
  always @*
  begin
    m1 = {2'b00, divisor_register_q};
    m2 = {1'b0, divisor_register_q, 1'b0};
    m3 = m1 + m2;
    // a large divisor needs a higher remainder before guessing three
    if (acc_q[56:54] >= 3'h4 ||
        (acc_q[56:54] >= 3'h3 && divisor_register_q[53] == 1'b0))
      est = 2'h3;
    else if (acc_q[56:54] >= 3'h2)
      est = 2'h2;
    else
      est = 2'h1;
    estimate_bit_low  = est[0];
    estimate_bit_high = est[1];
    case (est)
      2'h3:
      begin
        y_sub = m3;
        x_sub = m2;
      end
      2'h2:
      begin
        y_sub = m2;
        x_sub = m1;
      end
      default:
      begin
        y_sub = m1;
        x_sub = 57'h0;
      end
    endcase
    y_diff = {1'b0, acc_q} - {1'b0, y_sub};
    x_diff = {1'b0, acc_q} - {1'b0, x_sub};
    y_adder_carry = ~y_diff[57];
    qbits = y_adder_carry ? {estimate_bit_high, estimate_bit_low}
                          : est - 2'h1;
    // remainder realigned with the left shifter: reverse, shift, reverse
    for (i = 0; i < 32; i = i + 1)
      rem_rev[i] = acc_q[56 - i];
    rem_sh = rem_rev << divisor_shift_length_q;
    for (i = 0; i < 32; i = i + 1)
      rem_out[i] = rem_sh[31 - i];
    // two multiplier bits from the shift register's low end per pass
    prod = {1'b0, acc_q}
         + (quotient_shift_register_q[0] ? {2'b00, mcand_q} : 58'h0)
         + (quotient_shift_register_q[1] ? {1'b0, mcand_q, 1'b0}
                                         : 58'h0);
  end

  // floating normalization, range check and output selector
  always @*
  begin
    // single quotient sits low in the register; line it up with double
    qal = dbl_q ? quotient_shift_register_q
                : {quotient_shift_register_q[23:0], 32'h0};
    if (op_q == `IMDF_OP_FMUL)
      normalize_correction = ~acc_q[`IMDF_MANT_TOP];
    else
      normalize_correction = qal[`IMDF_MANT_TOP + 1];
    if (!normalize_correction)
      exp_fix = exp_sum;
    else if (op_q == `IMDF_OP_FMUL)
      exp_fix = exp_sum - 10'h001;
    else
      exp_fix = exp_sum + 10'h001;
    exponent_sum_top       = exp_fix[8];
    exponent_sum_extension = exp_fix[9];
    if (op_q == `IMDF_OP_FMUL)
      mant = normalize_correction ? {acc_q[51:0], 1'b0} : acc_q[52:0];
    else
      mant = normalize_correction ? qal[53:1] : qal[52:0];
    if (op_q == `IMDF_OP_FDIV && !rem_zero_q)
      mant[0] = 1'b1;
    if (op_q == `IMDF_OP_FMUL && (a_zero || b_zero))
      sel = `IMDF_ZERO_CODE;
    else if (op_q == `IMDF_OP_FDIV && b_zero)
      sel = `IMDF_SEL_ONES;
    else if (exponent_sum_top != exponent_sum_extension)
      sel = exponent_sum_extension ? `IMDF_SEL_ZERO
                                   : `IMDF_SEL_ONES;
    else if (normalize_correction)
      sel = (op_q == `IMDF_OP_FMUL) ? `IMDF_SEL_SHL : `IMDF_SEL_SHR;
    else
      sel = `IMDF_SEL_MANT;
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      cyc_q                     <= `IMDF_CYC_LOAD;
      op_q                      <= `IMDF_OP_IDIV;
      iter_q                    <= 6'h00;
      acc_q                     <= 57'h0;
      divisor_register_q        <= 55'h0;
      quotient_shift_register_q <= 56'h0;
      divisor_shift_length_q    <= 5'h00;
      a_neg_q                   <= 1'b0;
      b_neg_q                   <= 1'b0;
      dbl_q                     <= 1'b0;
      rem_zero_q                <= 1'b0;
      mcand_q                   <= 56'h0;
      result_q                  <= 64'h0;
      remainder_q               <= 32'h0;
      result_valid_q            <= 1'b0;
      busy_q                    <= 1'b0;
      overflow_flag_q           <= 1'b0;
      underflow_flag_q          <= 1'b0;
      output_select_code_q      <= 3'h0;
    end
    else
    begin
      result_valid_q <= 1'b0;
      case (cyc_q)
        `IMDF_CYC_LOAD:
        begin
          if (start)
          begin
            busy_q <= 1'b1;
            cyc_q  <= `IMDF_CYC_ITER;
            dbl_q  <= double_precision;
            quotient_shift_register_q <= 56'h0;
            rem_zero_q <= 1'b0;
            if (float_multiply_op)
            begin
              op_q   <= `IMDF_OP_FMUL;
              iter_q <= double_precision ? `IMDF_DBL_ITER
                                         : `IMDF_SGL_ITER;
              acc_q  <= 57'h0;
              if (double_precision)
              begin
                quotient_shift_register_q <=
                  {2'b00, 1'b1, first_operand_bus[52:0]};
                mcand_q <= {1'b1, second_operand_bus[52:0], 2'b00};
              end
              else
              begin
                quotient_shift_register_q <=
                  {33'h0, 1'b1, first_operand_bus[21:0]};
                mcand_q <= {1'b0, 1'b1, second_operand_bus[21:0], 32'h0};
              end
            end
            else if (float_divide_op)
            begin
              op_q   <= `IMDF_OP_FDIV;
              iter_q <= double_precision ? `IMDF_DBL_ITER
                                         : `IMDF_SGL_ITER;
              if (double_precision)
              begin
                divisor_register_q <=
                  {1'b1, second_operand_bus[52:0], 1'b0};
                acc_q <= {2'b00, 1'b1, first_operand_bus[52:0], 1'b0};
              end
              else
              begin
                divisor_register_q <=
                  {1'b1, second_operand_bus[21:0], 32'h0};
                acc_q <= {2'b00, 1'b1, first_operand_bus[21:0], 32'h0};
              end
            end
            else
            begin
              op_q <= `IMDF_OP_IDIV;
              a_neg_q <= first_operand_bus[31];
              b_neg_q <= second_operand_bus[31];
              divisor_shift_length_q <= 5'h1F - lead;
              divisor_register_q <= {23'h0, b_mag} << (6'h17 + 6'h1F
                                    - {1'b0, lead});
              // sixteen minus half the leading-one position, so a large
              // divisor (short shift) needs fewer passes
              iter_q <= {1'b0, `IMDF_IDIV_BASE}
                        - {2'b00, lead[4:1]};
              if (lead[0] == 1'b0)
                acc_q <= {1'b0, a_mag, 22'h0, 2'b00};
              else
                acc_q <= {2'b00, a_mag, 21'h0, 2'b00};
            end
          end
        end
        `IMDF_CYC_ITER:
        begin
          if (iter_q == 6'h00)
            cyc_q <= `IMDF_CYC_NORMALIZE_CORRECTION;
          else
          begin
            iter_q <= iter_q - 6'h01;
            if (op_q == `IMDF_OP_FMUL)
            begin
              // shift-add, two multiplier bits per pass
              acc_q <= {1'b0, prod[57:2]};
              quotient_shift_register_q <=
                {prod[1:0], quotient_shift_register_q[55:2]};
            end
            else
            begin
              acc_q <= y_adder_carry ? {y_diff[54:0], 2'b00}
                                     : {x_diff[54:0], 2'b00};
              quotient_shift_register_q <=
                {quotient_shift_register_q[53:0], qbits};
              if ((y_adder_carry ? y_diff : x_diff) == 58'h0)
                rem_zero_q <= 1'b1;
            end
          end
        end
        `IMDF_CYC_NORMALIZE_CORRECTION:
        begin
          cyc_q <= `IMDF_CYC_PRES;
          if (op_q == `IMDF_OP_IDIV)
          begin
            // sign inversion is two's complement, so zero stays zero
            remainder_q <= a_neg_q ? ~rem_out + 32'h1 : rem_out;
            if (a_neg_q ^ b_neg_q)
              quotient_shift_register_q <=
                ~quotient_shift_register_q + 56'h1;
          end
        end
        default:
        begin
          // result goes out in the last cycle only
          cyc_q          <= `IMDF_CYC_LOAD;
          busy_q         <= 1'b0;
          result_valid_q <= 1'b1;
          if (op_q == `IMDF_OP_IDIV)
          begin
            result_q <= {32'h0, quotient_shift_register_q[31:0]};
            output_select_code_q <= `IMDF_SEL_MANT;
            overflow_flag_q <= 1'b0;
            underflow_flag_q <= 1'b0;
          end
          else
          begin
            output_select_code_q <= sel;
            overflow_flag_q <= (sel == `IMDF_SEL_ONES);
            underflow_flag_q <= (sel == `IMDF_SEL_ZERO) &&
                                !(op_q == `IMDF_OP_FMUL &&
                                  (a_zero || b_zero));
            if (sel == `IMDF_SEL_ONES)
              result_q <= {res_sign, 63'h7FFFFFFFFFFFFFFF};
            else if (sel == `IMDF_SEL_ZERO)
              result_q <= 64'h0;
            else if (dbl_q)
              result_q <= {res_sign, ~exp_fix[8], exp_fix[7:0], 1'b0,
                           mant};
            else
              result_q <= {32'h0, res_sign, ~exp_fix[8], exp_fix[7:0],
                           mant[52:31]};
          end
        end
      endcase
    end
  end
endmodule
